// [include/enki_pkg.sv]
// Package of offsets, fields, reset values and timing for the NMI/key block.
package enki_pkg;

  // ==========================================================
  // Register offsets (byte addresses on the APB bus).
  localparam logic [7:0] ENKI_OFS_MODE   = 8'h00;
  localparam logic [7:0] ENKI_OFS_PORT   = 8'h04;
  localparam logic [7:0] ENKI_OFS_DEBCNT = 8'h08;
  localparam logic [7:0] ENKI_OFS_KEYDIR = 8'h0c;
  localparam logic [7:0] ENKI_OFS_STATUS = 8'h10;
  localparam logic [7:0] ENKI_OFS_MASK   = 8'h14;

  // ==========================================================
  // Field positions.
  localparam int ENKI_NMI_EN_BIT  = 4;
  localparam int ENKI_PIN_LVL_BIT = 5;
  localparam int ENKI_KEY_DIR_LSB = 4;
  localparam int ENKI_ST_NMI_BIT  = 0;
  localparam int ENKI_ST_KEY_BIT  = 1;

  // ==========================================================
  // Reset values.
  localparam logic [7:0] ENKI_DEBCNT_RST = 8'hff;
  localparam logic [3:0] ENKI_KEYDIR_RST = 4'h0;
  localparam logic [1:0] ENKI_MASK_RST   = 2'h0;

  // ==========================================================
  // Timing: pclk cycles between two debounce samples.
  localparam int ENKI_SAMPLE_DIV = 4;

  // Bus slave answer states.
  typedef enum logic {ENKI_APB_IDLE, ENKI_APB_RESP} enki_apb_state_type;

endpackage

// [rtl/enki_debounce.sv]
// Digital debounce filter for the non-maskable interrupt input.
`timescale 1ns/1ps
module enki_debounce
  import enki_pkg::*;
#(
  parameter int CNT_W = 8,
  parameter int DIV   = ENKI_SAMPLE_DIV
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             raw,
  input  wire logic [CNT_W-1:0] limit,
  output logic                  level
);

  // The divider needs at least two states to make a slower tick.
  if (DIV < 2 || CNT_W < 1) begin : g_chk
    $error("enki_debounce: DIV must be 2 or more");
  end

  logic [15:0]      div_ff;   // Sample divider.
  logic             tick;     // One-cycle sample enable.
  logic [CNT_W-1:0] cnt_ff;   // Samples that differed so far.
  logic             level_ff; // Accepted level, idle high.

  assign tick  = (div_ff == 16'(DIV - 1));
  assign level = level_ff;

  // ==========================================================
  // Sample divider.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= 16'h0000;
    end else if (tick) begin
      div_ff <= 16'h0000;
    end else begin
      div_ff <= div_ff + 16'h0001;
    end
  end

  // ==========================================================
  // A new level is taken only once it has differed for limit + 1 samples in a row,
  // so a pulse shorter than that never reaches the edge detector.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff   <= '0;
      level_ff <= 1'b1;
    end else if (tick) begin
      if (raw == level_ff) begin
        cnt_ff <= '0;
      end else if (cnt_ff >= limit) begin
        cnt_ff   <= '0;
        level_ff <= raw;
      end else begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end

  a_level_on_tick: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(level_ff) |-> $past(tick) && $past(cnt_ff) >= $past(limit))
    else $error("debounce level changed before the count was reached");

  a_noise_reject: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && raw == level_ff) |=> cnt_ff == '0 && $stable(level_ff))
    else $error("matching sample did not reset the debounce count");

endmodule

// [rtl/enki_key_detect.sv]
// Key input detector: AND of enabled key pins, falling edge request.
`timescale 1ns/1ps
module enki_key_detect (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [3:0] pins,
  input  wire logic [3:0] dir,
  output logic            fall
);

  logic comb;    // AND of the pins that are inputs.
  logic comb_ff; // Previous combined level.
  logic fall_ff; // Request pulse.

  // Output pins (dir 1) are forced high so they never trigger.
  assign comb = &(pins | dir);
  assign fall = fall_ff;

  // ==========================================================
  // Edge detection on the combined level. A pin held low keeps the
  // AND low, so further keys cannot make a new edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comb_ff <= 1'b1;
      fall_ff <= 1'b0;
    end else begin
      comb_ff <= comb;
      fall_ff <= comb_ff & ~comb;
    end
  end

  a_key_fall_req: assert property (@(posedge pclk) disable iff (!presetn)
    (comb_ff && |(~pins & ~dir)) |=> fall_ff)
    else $error("input key pin went low without a request");

  a_key_held_block: assert property (@(posedge pclk) disable iff (!presetn)
    !comb_ff |=> !fall_ff)
    else $error("request raised while a key was still held low");

  a_key_and_edge: assert property (@(posedge pclk) disable iff (!presetn)
    fall_ff |-> $past(comb_ff) && !$past(comb))
    else $error("request without a falling combined level");

endmodule

// [rtl/enki_top.sv]
// Top of the external NMI and key input interrupt block with APB registers.
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps

// Functional notes
// - NMI request on falling edge once enabled.
// - Enabled NMI ignores every mask setting; here only nmi_req does, irq still follows the NMI mask bit.
// - Pin level always readable in port register.
// - Reset leaves NMI off, pin is GPIO.
// - Enable locks set until reset.
// - NMI input is debounced before edge detect.
// - Low on input key pin raises request.
// - Key request wakes from stop and wait.
// - Held low key blocks other key detection.
module enki_top
  import enki_pkg::*;
#(
  parameter int CNT_W = 8,
  parameter int DIV   = ENKI_SAMPLE_DIV
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        nonmask_pin,
  input  wire logic [3:0]  key_input_pins,
  input  wire logic        stop_mode,
  input  wire logic        wait_mode,
  output logic             nmi_enabled,
  output logic             nmi_req,
  output logic             key_req,
  output logic             wake_req,
  output logic             irq
);

  // The debounce count register is eight bits wide on the bus.
  if (CNT_W != 8) begin : g_chk
    $error("enki_top: CNT_W must be 8");
  end

  // ==========================================================
  // Helper functions.

  // True for every mapped register offset.
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == ENKI_OFS_MODE) || (a == ENKI_OFS_PORT) ||
              (a == ENKI_OFS_DEBCNT) || (a == ENKI_OFS_KEYDIR) ||
              (a == ENKI_OFS_STATUS) || (a == ENKI_OFS_MASK);
  endfunction

  // ==========================================================
  // Registers.
  enki_apb_state_type state_ff;        // Bus answer state.
  logic [31:0]        prdata_ff;       // Read data.
  logic               pready_ff;       // Transfer complete.
  logic               pslverr_ff;      // Unmapped address.
  logic               nmi_en_ff;       // NMI enable, locked once set.
  logic [7:0]         nonmask_debounce_count; // Debounce limit.
  logic [3:0]         key_pin_direction_bits; // 1 = output pin.
  logic [1:0]         status_ff;       // Sticky events.
  logic [1:0]         mask_ff;         // 1 = event drives irq.
  logic               filt_prev_ff;    // Previous debounced level.
  logic               nmi_req_ff;      // NMI request pulse.
  logic               key_req_ff;      // Key request pulse.
  logic               wake_ff;         // Wake pulse.
  logic               irq_ff;          // Combined interrupt level.

  // ==========================================================
  // Combinational terms.
  logic        acc;        // Completing edge of an access.
  logic        wr_acc;     // Completing write.
  logic        filt;       // Debounced NMI input.
  logic        key_fall;   // Key detector pulse.
  logic        nmi_ev;     // NMI event this cycle.
  logic [1:0]  rd_clr;     // Status bits cleared by a read.
  logic [1:0]  nxt_status; // Next status.
  logic [1:0]  nxt_mask;   // Next mask.
  logic [31:0] rd_mux;     // Read data selected by address.

  assign acc    = (state_ff == ENKI_APB_RESP) && psel && penable;
  assign wr_acc = acc && pwrite;

  // Filtered falling edge, gated only by the enable.
  assign nmi_ev = nmi_en_ff && filt_prev_ff && !filt;

  // ==========================================================
  // Read data mux; unmapped offsets read as zero.
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (paddr == ENKI_OFS_MODE) begin
      rd_mux[ENKI_NMI_EN_BIT] = nmi_en_ff;
    end else if (paddr == ENKI_OFS_PORT) begin
      // Live pin level, whether or not the NMI is enabled.
      rd_mux[ENKI_PIN_LVL_BIT] = nonmask_pin;
    end else if (paddr == ENKI_OFS_DEBCNT) begin
      rd_mux[7:0] = nonmask_debounce_count;
    end else if (paddr == ENKI_OFS_KEYDIR) begin
      rd_mux[ENKI_KEY_DIR_LSB +: 4] = key_pin_direction_bits;
    end else if (paddr == ENKI_OFS_STATUS) begin
      rd_mux[1:0] = status_ff;
    end else if (paddr == ENKI_OFS_MASK) begin
      rd_mux[1:0] = mask_ff;
    end
  end

  // ==========================================================
  // APB answer: one wait state, then pready for one cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff   <= ENKI_APB_IDLE;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      case (state_ff)
        ENKI_APB_IDLE: begin
          if (psel && penable) begin
            state_ff   <= ENKI_APB_RESP;
            pready_ff  <= 1'b1;
            pslverr_ff <= !addr_ok(paddr);
            prdata_ff  <= pwrite ? 32'h0000_0000 : rd_mux;
          end
        end
        default: begin
          state_ff   <= ENKI_APB_IDLE;
          pready_ff  <= 1'b0;
          pslverr_ff <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // NMI enable: writing 1 sets it, writing 0 is ignored, so only
  // reset brings the pin back to plain GPIO use.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_en_ff <= 1'b0;
    end else if (wr_acc && paddr == ENKI_OFS_MODE && pwdata[ENKI_NMI_EN_BIT]) begin
      nmi_en_ff <= 1'b1;
    end
  end

  // ==========================================================
  // Debounce count and key direction registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nonmask_debounce_count <= ENKI_DEBCNT_RST;
      key_pin_direction_bits <= ENKI_KEYDIR_RST;
    end else if (wr_acc) begin
      if (paddr == ENKI_OFS_DEBCNT) begin
        nonmask_debounce_count <= pwdata[7:0];
      end else if (paddr == ENKI_OFS_KEYDIR) begin
        key_pin_direction_bits <= pwdata[ENKI_KEY_DIR_LSB +: 4];
      end
    end
  end

  // ==========================================================
  // Status and mask. A read clears only the bits it returned, and an
  // event in the same cycle still sets its bit, so none is lost.
  always_comb begin
    rd_clr = 2'h0;
    if (acc && !pwrite && paddr == ENKI_OFS_STATUS) begin
      rd_clr = prdata_ff[1:0];
    end
    nxt_status = status_ff & ~rd_clr;
    nxt_status[ENKI_ST_NMI_BIT] = nxt_status[ENKI_ST_NMI_BIT] | nmi_ev;
    nxt_status[ENKI_ST_KEY_BIT] = nxt_status[ENKI_ST_KEY_BIT] | key_fall;
    nxt_mask = mask_ff;
    if (wr_acc && paddr == ENKI_OFS_MASK) begin
      nxt_mask = pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_ff <= 2'h0;
      mask_ff   <= ENKI_MASK_RST;
      irq_ff    <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      mask_ff   <= nxt_mask;
      irq_ff    <= |(nxt_status & nxt_mask);
    end
  end

  // ==========================================================
  // NMI path. The request pulse bypasses the mask register entirely;
  // the status bit drives irq only when its mask bit is set.
  enki_debounce #(
    .CNT_W (CNT_W),
    .DIV   (DIV)
  ) u_deb (
    .pclk    (pclk),
    .presetn (presetn),
    .raw     (nonmask_pin),
    .limit   (nonmask_debounce_count),
    .level   (filt)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_prev_ff <= 1'b1;
      nmi_req_ff   <= 1'b0;
    end else begin
      filt_prev_ff <= filt;
      nmi_req_ff   <= nmi_ev;
    end
  end

  // ==========================================================
  // Key path and wake-up.
  enki_key_detect u_key (
    .pclk    (pclk),
    .presetn (presetn),
    .pins    (key_input_pins),
    .dir     (key_pin_direction_bits),
    .fall    (key_fall)
  );

  // Wake is raised in stop or wait; the pulse needs no running core.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_req_ff <= 1'b0;
      wake_ff    <= 1'b0;
    end else begin
      key_req_ff <= key_fall;
      wake_ff    <= key_fall && (stop_mode || wait_mode);
    end
  end

  // ==========================================================
  // Outputs.
  assign prdata      = prdata_ff;
  assign pready      = pready_ff;
  assign pslverr     = pslverr_ff;
  assign nmi_enabled = nmi_en_ff;
  assign nmi_req     = nmi_req_ff;
  assign key_req     = key_req_ff;
  assign wake_req    = wake_ff;
  assign irq         = irq_ff;

  // ==========================================================
  // Assertions.
  a_nmi_edge_req: assert property (@(posedge pclk) disable iff (!presetn)
    (nmi_en_ff && $fell(filt)) |=> nmi_req_ff)
    else $error("enabled NMI edge gave no request");

  a_nmi_no_mask: assert property (@(posedge pclk) disable iff (!presetn)
    (nmi_en_ff && $fell(filt) && !mask_ff[ENKI_ST_NMI_BIT]) |=> nmi_req_ff)
    else $error("masked NMI was blocked");

  a_pin_readable: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(pready_ff) && !pwrite && paddr == ENKI_OFS_PORT)
      |-> prdata_ff[ENKI_PIN_LVL_BIT] == $past(nonmask_pin))
    else $error("port read did not return the pin level");

  a_nmi_off_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !nmi_en_ff |=> !nmi_req_ff)
    else $error("NMI request while disabled");

  a_en_locked: assert property (@(posedge pclk) disable iff (!presetn)
    nmi_en_ff |=> nmi_en_ff)
    else $error("NMI enable was cleared without reset");

  a_key_wake: assert property (@(posedge pclk) disable iff (!presetn)
    (key_fall && (stop_mode || wait_mode)) |=> wake_ff && key_req_ff)
    else $error("key event in stop or wait gave no wake");

  a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 irq_ff == |(status_ff & mask_ff))
    else $error("irq does not match masked status");

  c_nmi_req: cover property (@(posedge pclk) disable iff (!presetn) nmi_req_ff);
  c_key_wake: cover property (@(posedge pclk) disable iff (!presetn) wake_ff);
  c_status_clr: cover property (@(posedge pclk) disable iff (!presetn)
    |rd_clr);
  c_bus_err: cover property (@(posedge pclk) disable iff (!presetn) pslverr_ff);

endmodule

// [tb/enki_pin_source.sv]
// Model of the outside world that drives the NMI and key pins.
`timescale 1ns/1ps
module enki_pin_source (
  input  wire logic  pclk,
  output logic       nonmask_pin,
  output logic [3:0] key_input_pins
);
  // ==========================================================
  // Idle levels: a quiet NMI line and released keys read high.
  initial begin
    nonmask_pin    = 1'b1;
    key_input_pins = 4'hf;
  end

  // Moves the NMI line just after a clock edge.
  task automatic set_nmi(input logic lvl);
    @(posedge pclk);
    nonmask_pin <= lvl;
  endtask

  // Keys are plain digital levels, never analog voltages.
  task automatic set_keys(input logic [3:0] v);
    @(posedge pclk);
    key_input_pins <= v;
  endtask

  // A short low spike, as noise on the NMI line would make.
  task automatic pulse_nmi(input int n);
    set_nmi(1'b0);
    repeat (n) @(posedge pclk);
    nonmask_pin <= 1'b1;
  endtask
endmodule

// [tb/testbench.sv]
// Self-checking bench for the NMI and key input interrupt block.
`timescale 1ns/1ps
module testbench;
  import enki_pkg::*;
  // ==========================================================
  // Stimulus, design outputs and the reference model state.
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        stop_mode;
  logic        wait_mode;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        nonmask_pin;
  logic [3:0]  key_input_pins;
  logic        nmi_enabled;
  logic        nmi_req;
  logic        key_req;
  logic        wake_req;
  logic        irq;
  int          mismatches = 0;
  int          n_tests    = 0;
  int          n_nmi      = 0;
  int          n_key      = 0;
  int          n_wake     = 0;
  int          exp_nmi    = 0;
  int          exp_key    = 0;
  int          exp_wake   = 0;
  logic [31:0] seed       = 32'h0000_1408;
  logic [31:0] rdat;
  logic        rerr;
  int          p;

  always #2.5 pclk = ~pclk;

  // DIV of 2 keeps the debounce waits short.
  enki_top #(.CNT_W(8), .DIV(2)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .nonmask_pin(nonmask_pin),
    .key_input_pins(key_input_pins), .stop_mode(stop_mode),
    .wait_mode(wait_mode), .nmi_enabled(nmi_enabled), .nmi_req(nmi_req),
    .key_req(key_req), .wake_req(wake_req), .irq(irq)
  );

  enki_pin_source src (
    .pclk(pclk), .nonmask_pin(nonmask_pin), .key_input_pins(key_input_pins)
  );

  // Request pulses last one cycle, so every edge is counted.
  always @(posedge pclk) begin
    n_nmi  <= n_nmi + int'(nmi_req === 1'b1);
    n_key  <= n_key + int'(key_req === 1'b1);
    n_wake <= n_wake + int'(wake_req === 1'b1);
  end

  // ==========================================================
  // Helpers.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; waits for pready under a bound.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) mismatches++;
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, rdat, exp);
  endtask

  // Compares the pulse counters with the model after the pins settle.
  task automatic counts();
    repeat (30) @(posedge pclk);
    chk("nmi count", n_nmi, exp_nmi);
    chk("key count", n_key, exp_key);
    chk("wake count", n_wake, exp_wake);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // The whole run needs well under a thousand cycles; the limit allows 20000.
  initial begin
    #(5 * 20000);
    mismatches++;
    results();
  end

  // ==========================================================
  // Main sequence.
  initial begin
    // Idle bus, run mode and reset asserted from time zero.
    pclk      = 1'b0;
    presetn   = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0000_0000;
    stop_mode = 1'b0;
    wait_mode = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    chk("enable at reset", nmi_enabled, 1'b0);
    rd("mode", ENKI_OFS_MODE, 32'h0000_0000);
    rd("debcnt", ENKI_OFS_DEBCNT, 32'h0000_00ff);
    rd("keydir", ENKI_OFS_KEYDIR, 32'h0000_0000);
    rd("mask", ENKI_OFS_MASK, 32'h0000_0000);
    rd("port high", ENKI_OFS_PORT, 32'h0000_0020);
    seed = lfsr(seed);
    apb(1'b1, 8'h18, seed);
    chk("unmapped err", rerr, 1'b1);
    rd("unmapped", 8'h18, 32'h0000_0000);
    apb(1'b1, ENKI_OFS_DEBCNT, 32'h0000_0003);
    // Disabled: a real falling edge must stay silent.
    src.set_nmi(1'b0);
    counts();
    rd("port low", ENKI_OFS_PORT, 32'h0000_0000);
    src.set_nmi(1'b1);
    apb(1'b1, ENKI_OFS_MODE, 32'h0000_0010);
    apb(1'b1, ENKI_OFS_MODE, 32'h0000_0000);
    chk("enable locked", nmi_enabled, 1'b1);
    rd("mode set", ENKI_OFS_MODE, 32'h0000_0010);
    // Three cycles span at most two samples, short of four.
    src.pulse_nmi(3);
    counts();
    src.pulse_nmi(30);
    exp_nmi++;
    counts();
    chk("nmi irq masked", irq, 1'b0);
    apb(1'b1, ENKI_OFS_MASK, 32'h0000_0003);
    @(posedge pclk);
    chk("irq on", irq, 1'b1);
    rd("status nmi", ENKI_OFS_STATUS, 32'h0000_0001);
    @(posedge pclk);
    chk("irq cleared", irq, 1'b0);
    apb(1'b1, ENKI_OFS_DEBCNT, 32'h0000_00ff);
    // Key presses in run, stop and wait modes on random pins.
    for (int m = 0; m < 3; m++) begin
      seed = lfsr(seed);
      p = int'(seed[1:0]);
      @(posedge pclk);
      stop_mode <= (m == 1);
      wait_mode <= (m == 2);
      src.set_keys(~(4'h1 << p));
      exp_key++;
      exp_wake += int'(m != 0);
      counts();
      src.set_keys(~(4'h1 << p) & ~(4'h1 << ((p + 1) % 4)));
      counts();
      src.set_keys(4'hf);
      counts();
      chk("key irq", irq, 1'b1);
      rd("status key", ENKI_OFS_STATUS, 32'h0000_0002);
    end
    @(posedge pclk);
    stop_mode <= 1'b0;
    wait_mode <= 1'b0;
    apb(1'b1, ENKI_OFS_KEYDIR, 32'h0000_00f0);
    rd("keydir out", ENKI_OFS_KEYDIR, 32'h0000_00f0);
    src.set_keys(4'h0);
    counts();
    src.set_keys(4'hf);
    // Only a reset may drop the locked enable.
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("enable after reset", nmi_enabled, 1'b0);
    presetn <= 1'b1;
    results();
  end
endmodule
